/* inc/hrec_pkg.sv */
// Purpose: shared constants and types of the fine edge configuration block
// Assumes: 32-bit AXI4-Lite, byte address = 4 * register index
// Notes: register indices kept as printed where a figure exists
package hrec_pkg;
	localparam int ADDR_W = 8;
	// register indices
	localparam logic [5:0] IDX_PHASE_FINE = 6'h02;
	localparam logic [5:0] IDX_COARSE_CTRL = 6'h07;
	localparam logic [5:0] IDX_FINE_CMP = 6'h08;
	localparam logic [5:0] IDX_COARSE_CMP = 6'h09;
	localparam logic [5:0] IDX_CONFIG = 6'h20;
	localparam logic [5:0] IDX_STATUS = 6'h21;
	localparam logic [5:0] IDX_UNLOCK = 6'h22;
	localparam logic [5:0] IDX_COMBINED = 6'h28;
	// config fields
	localparam int CFG_LOAD_BIT = 3;
	localparam int CFG_SRC_BIT = 2;
	localparam int CFG_EDGE_LO = 0;
	localparam int STEP_LO = 8;
	// reset values
	localparam logic [3:0] CFG_RESET = 4'h0;
	localparam logic [7:0] STEP_RESET = 8'h00;
	localparam logic [15:0] COARSE_RESET = 16'h0000;
	localparam logic [1:0] CCTRL_RESET = 2'h0;
	// edge select codes
	localparam logic [1:0] EDGE_OFF = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	// coarse load modes
	localparam logic [1:0] CLOAD_ZERO = 2'h0;
	localparam logic [1:0] CLOAD_PRD = 2'h1;
	localparam logic [1:0] CLOAD_EITHER = 2'h2;
	localparam logic [1:0] CLOAD_FREEZE = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		WR_IDLE = 3'b001,
		WR_EXEC = 3'b010,
		WR_RESP = 3'b100
	} hrec_wr_state_type;

	// byte-lane merge of a 16-bit register
	function automatic logic [15:0] hrec_merge16(input logic [15:0] old_v,
		input logic [15:0] new_v, input logic [1:0] strb);
		hrec_merge16 = {strb[1] ? new_v[15:8] : old_v[15:8],
			strb[0] ? new_v[7:0] : old_v[7:0]};
	endfunction
endpackage

/* tb/hrec_fine_edge_tb.sv */
// Purpose: self-checking bench of the fine edge configuration block
// Assumes: AXI4-Lite master tasks, counter events driven as one-cycle pulses
// Notes: expectations come from bench functions, never from the design outputs
`timescale 1ns/10ps
module hrec_fine_edge_tb;
	import hrec_pkg::*;
	localparam logic [7:0] A_PH = {IDX_PHASE_FINE, 2'b00};
	localparam logic [7:0] A_CC = {IDX_COARSE_CTRL, 2'b00};
	localparam logic [7:0] A_FC = {IDX_FINE_CMP, 2'b00};
	localparam logic [7:0] A_CO = {IDX_COARSE_CMP, 2'b00};
	localparam logic [7:0] A_CF = {IDX_CONFIG, 2'b00};
	localparam logic [7:0] A_ST = {IDX_STATUS, 2'b00};
	localparam logic [7:0] A_UL = {IDX_UNLOCK, 2'b00};
	localparam logic [7:0] A_CB = {IDX_COMBINED, 2'b00};
	localparam logic [7:0] A_NONE = 8'h40;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hF;
	logic counter_at_zero = 1'b0, counter_at_period = 1'b0;
	logic coarse_rise_req = 1'b0, coarse_fall_req = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, edge_rise, edge_fall;
	logic mep_rise_en, mep_fall_en;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, cw;
	logic [15:0] compare_a_active, prev_co, new_co;
	logic [7:0] mep_step, fn, ph;
	logic [3:0] cfg;
	int n_errors = 0;
	int total_checks = 0;

	hrec_fine_edge i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.counter_at_zero(counter_at_zero), .counter_at_period(counter_at_period),
		.coarse_rise_req(coarse_rise_req), .coarse_fall_req(coarse_fall_req),
		.compare_a_active(compare_a_active), .edge_rise(edge_rise), .edge_fall(edge_fall),
		.mep_step(mep_step), .mep_rise_en(mep_rise_en), .mep_fall_en(mep_fall_en));

	// 50 MHz clock
	always #10 aclk = ~aclk;

	// verdict and end of run
	task automatic complete_run();
		if (n_errors == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch t=%0t resp got=%h exp=%h", $time, got, exp);
		end
	endtask

	// expected {step, rise enable, fall enable} from config and fine values
	function automatic logic [9:0] exp_mep(input logic [3:0] c, input logic [7:0] f,
		input logic [7:0] p);
		logic [7:0] s;
		s = c[CFG_SRC_BIT] ? p : f;
		// disabled edges or a zero step: no fine action at all
		if (c[1:0] == EDGE_OFF || s == 8'h00)
			return 10'h000;
		return {s, c[1:0] == EDGE_RISE || c[1:0] == EDGE_BOTH,
			c[1:0] == EDGE_FALL || c[1:0] == EDGE_BOTH};
	endfunction

	// software combined word: scaled duty plus range and rounding offset
	function automatic logic [31:0] sw_word(input logic [15:0] duty, input logic [15:0] sf);
		return {16'h0, duty} * {16'h0, sf} + 32'h00000180;
	endfunction

	// write: address and data offered together, each released when taken
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ad;
		logic wd;
		ad = 1'b0;
		wd = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge aclk);
			if (!ad && awready === 1'b1) begin
				ad = 1'b1;
				awvalid <= 1'b0;
			end
			if (!wd && wready === 1'b1) begin
				wd = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		cmp_resp(bresp, er);
		bready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		cmp_word(rdata, ed);
		cmp_resp(rresp, er);
		rready <= 1'b0;
		@(posedge aclk);
	endtask

	// one-cycle counter event, then let the loads settle
	task automatic ev(input logic z, input logic p);
		counter_at_zero <= z;
		counter_at_period <= p;
		@(posedge aclk);
		counter_at_zero <= 1'b0;
		counter_at_period <= 1'b0;
		repeat (3) @(posedge aclk);
	endtask

	task automatic chk_mep(input logic [9:0] e);
		cmp_word({22'h0, mep_step, mep_rise_en, mep_fall_en}, {22'h0, e});
	endtask

	task automatic set_cfg(input logic [3:0] c);
		cfg = c;
		axw(A_CF, {28'h0, c}, RESP_OKAY);
		// coarse load mode follows the fine load event
		axw(A_CC, {31'h0, c[CFG_LOAD_BIT]}, RESP_OKAY);
	endtask

	// hang guard, well above the expected run length
	initial begin
		repeat (20000) @(posedge aclk);
		n_errors++;
		complete_run();
	end

	// main sequence
	initial begin
		void'($urandom(63311));
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axr(A_CF, 32'h0, RESP_OKAY);
		axr(A_FC, 32'h0, RESP_OKAY);
		axr(A_ST, 32'h0, RESP_OKAY);
		axw(A_CF, 32'h0000000A, RESP_SLVERR);
		axr(A_CF, 32'h0, RESP_OKAY);
		axw(A_ST, 32'h1, RESP_SLVERR);
		axr(A_NONE, 32'h0, RESP_SLVERR);
		axw(A_UL, 32'h1, RESP_OKAY);
		axr(A_ST, 32'h1, RESP_OKAY);
		set_cfg(4'h0);
		axw(A_FC, 32'h000055FF, RESP_OKAY);
		ev(1'b1, 1'b0);
		chk_mep(10'h000);
		// coarse edges pass through one cycle late
		coarse_rise_req <= 1'b1;
		@(posedge aclk);
		coarse_rise_req <= 1'b0;
		coarse_fall_req <= 1'b1;
		@(posedge aclk);
		cmp_word({30'h0, edge_rise, edge_fall}, 32'h2);
		coarse_fall_req <= 1'b0;
		@(posedge aclk);
		cmp_word({30'h0, edge_rise, edge_fall}, 32'h1);
		for (int e = 0; e < 4; e++) begin
			set_cfg({2'b00, 2'(e)});
			chk_mep(exp_mep(cfg, 8'h55, 8'h00));
		end
		// load on period: a zero event must not load
		set_cfg(4'hB);
		axw(A_FC, 32'h00009A00, RESP_OKAY);
		ev(1'b1, 1'b0);
		chk_mep(exp_mep(cfg, 8'h55, 8'h00));
		ev(1'b0, 1'b1);
		chk_mep(exp_mep(cfg, 8'h9A, 8'h00));
		set_cfg(4'h3);
		axw(A_FC, 32'h00003C00, RESP_OKAY);
		ev(1'b0, 1'b1);
		chk_mep(exp_mep(cfg, 8'h9A, 8'h00));
		ev(1'b1, 1'b0);
		chk_mep(exp_mep(cfg, 8'h3C, 8'h00));
		// phase control: phase step drives, period event ignored
		set_cfg(4'hE);
		axw(A_PH, 32'h000071FF, RESP_OKAY);
		axr(A_PH, 32'h00007100, RESP_OKAY);
		chk_mep(exp_mep(cfg, 8'h3C, 8'h71));
		axw(A_FC, 32'h000022FF, RESP_OKAY);
		axr(A_FC, 32'h00002200, RESP_OKAY);
		ev(1'b0, 1'b1);
		set_cfg(4'hA);
		chk_mep(exp_mep(cfg, 8'h3C, 8'h71));
		ev(1'b0, 1'b1);
		chk_mep(exp_mep(cfg, 8'h22, 8'h71));
		// step boundaries 0, 1 and FF
		set_cfg(4'h1);
		axw(A_FC, 32'h00000000, RESP_OKAY);
		ev(1'b1, 1'b0);
		cmp_word({24'h0, mep_step}, 32'h0);
		axw(A_FC, 32'h00000100, RESP_OKAY);
		ev(1'b1, 1'b0);
		chk_mep(exp_mep(cfg, 8'h01, 8'h71));
		// combined word updates coarse and fine together
		axw(A_CB, 32'h1234FF00, RESP_OKAY);
		ev(1'b1, 1'b0);
		cmp_word({16'h0, compare_a_active}, 32'h1234);
		chk_mep(exp_mep(cfg, 8'hFF, 8'h71));
		axr(A_CO, 32'h00001234, RESP_OKAY);
		axr(A_FC, 32'h0000FF00, RESP_OKAY);
		// software word from a random duty and scale, offset added after scaling
		cw = sw_word(16'($urandom()), 16'($urandom()));
		axw(A_CB, cw, RESP_OKAY);
		ev(1'b1, 1'b0);
		cmp_word({16'h0, compare_a_active}, {16'h0, cw[31:16]});
		chk_mep(exp_mep(cfg, cw[15:8], 8'h71));
		// coarse load modes against a zero event, fine edges off meanwhile
		set_cfg(4'h0);
		prev_co = cw[31:16];
		for (int m = 0; m < 4; m++) begin
			new_co = 16'($urandom());
			axw(A_CC, 32'(m), RESP_OKAY);
			axw(A_CO, {16'h0, new_co}, RESP_OKAY);
			ev(1'b1, 1'b0);
			if (2'(m) == CLOAD_ZERO || 2'(m) == CLOAD_EITHER)
				prev_co = new_co;
			cmp_word({16'h0, compare_a_active}, {16'h0, prev_co});
		end
		axw(A_CC, 32'h0, RESP_OKAY);
		// random configurations and step values
		for (int k = 0; k < 16; k++) begin
			fn = 8'($urandom_range(255, 1));
			ph = 8'($urandom_range(255, 1));
			set_cfg(4'($urandom()));
			axw(A_PH, {16'h0, ph, 8'($urandom())}, RESP_OKAY);
			axw(A_FC, {16'h0, fn, 8'($urandom())}, RESP_OKAY);
			ev(!(cfg[CFG_LOAD_BIT] && !cfg[CFG_SRC_BIT]), cfg[CFG_LOAD_BIT] && !cfg[CFG_SRC_BIT]);
			chk_mep(exp_mep(cfg, fn, ph));
		end
		// relock: config write refused, value kept
		set_cfg(4'h5);
		axw(A_UL, 32'h0, RESP_OKAY);
		axw(A_CF, 32'h0000000A, RESP_SLVERR);
		axr(A_CF, 32'h00000005, RESP_OKAY);
		// second reset in mid-run
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axr(A_CF, 32'h0, RESP_OKAY);
		chk_mep(10'h000);
		complete_run();
	end
endmodule

/* verilog/hrec_axil_slave.sv */
// Purpose: AXI4-Lite slave front end with one access each way
// Assumes: register decode answers combinationally
// Notes: write taken once both address and data are held
`timescale 1ns/10ps
module hrec_axil_slave (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [hrec_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [hrec_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic wr_en,
	output logic [hrec_pkg::ADDR_W-1:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	input wire logic wr_err,
	output logic [hrec_pkg::ADDR_W-1:0] rd_addr,
	input wire logic [31:0] rd_data,
	input wire logic rd_err
);
	import hrec_pkg::*;
	hrec_wr_state_type state;
	logic aw_held;
	logic w_held;

	assign awready = (state == WR_IDLE) && !aw_held;
	assign wready = (state == WR_IDLE) && !w_held;
	assign wr_en = (state == WR_EXEC);
	assign rd_addr = araddr;
	assign arready = !rvalid;

	// address and data capture, either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			wr_addr <= '0;
			wr_data <= 32'h00000000;
			wr_strb <= 4'h0;
		end else if (state == WR_EXEC) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
		end else begin
			if (awvalid && awready) begin
				aw_held <= 1'b1;
				wr_addr <= awaddr;
			end
			if (wvalid && wready) begin
				w_held <= 1'b1;
				wr_data <= wdata;
				wr_strb <= wstrb;
			end
		end
	end

	// write sequencing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= WR_IDLE;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else begin
			case (state)
			WR_IDLE: begin
				if (aw_held && w_held)
					state <= WR_EXEC;
			end
			WR_EXEC: begin
				bvalid <= 1'b1;
				bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
				state <= WR_RESP;
			end
			WR_RESP: begin
				if (bready) begin
					bvalid <= 1'b0;
					state <= WR_IDLE;
				end
			end
			default: state <= WR_IDLE;
			endcase
		end
	end

	// read answer registered one cycle after the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rdata <= rd_data;
			rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end
endmodule

/* verilog/hrec_fine_edge.sv */
// Purpose: fine edge configuration and fine step registers of a PWM channel
// Assumes: counter events and coarse edge requests come from the same clock
// Notes: delay line itself and coarse time base sit outside
`timescale 1ns/10ps
// Functional notes
// - config bit 3 picks fine load event
// - load event ignored in phase control
// - config bit 2 picks compare or phase
// - bits 1-0 pick edges, 00 disables
// - config writes only while unlocked
// - fine step bits 15-8, nonzero enables
// - phase fine step bits 15-8, low reserved
// - fine below coarse, one word writes both
module hrec_fine_edge (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [hrec_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [hrec_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic counter_at_zero,
	input wire logic counter_at_period,
	input wire logic coarse_rise_req,
	input wire logic coarse_fall_req,
	output logic [15:0] compare_a_active,
	output logic edge_rise,
	output logic edge_fall,
	output logic [7:0] mep_step,
	output logic mep_rise_en,
	output logic mep_fall_en
);
	import hrec_pkg::*;

	logic wr_en;
	logic [ADDR_W-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_err;
	logic [ADDR_W-1:0] rd_addr;
	logic [31:0] rd_data;
	logic rd_err;
	logic [5:0] wr_idx;
	logic [5:0] rd_idx;
	logic [3:0] fine_edge_config;
	logic protected_write_unlock;
	logic [1:0] coarse_compare_control;
	logic [7:0] phase_fine_field;
	logic fine_load_event_sel;
	logic positioner_source_sel;
	logic [1:0] fine_edge_select;
	logic fine_wr;
	logic coarse_wr;
	logic [7:0] fine_wr_value;
	logic [15:0] coarse_wr_value;
	logic fine_load;
	logic coarse_load;
	logic [7:0] fine_shadow;
	logic [7:0] fine_active;
	logic [15:0] coarse_shadow;
	logic [7:0] next_step;
	logic cfg_write;

	hrec_axil_slave u_bus (
		.aclk(aclk),
		.aresetn(aresetn),
		.awaddr(awaddr),
		.awvalid(awvalid),
		.awready(awready),
		.wdata(wdata),
		.wstrb(wstrb),
		.wvalid(wvalid),
		.wready(wready),
		.bresp(bresp),
		.bvalid(bvalid),
		.bready(bready),
		.araddr(araddr),
		.arvalid(arvalid),
		.arready(arready),
		.rdata(rdata),
		.rresp(rresp),
		.rvalid(rvalid),
		.rready(rready),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_err(wr_err),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_err(rd_err)
	);

	// word index from byte address
	function automatic logic [5:0] reg_index(input logic [ADDR_W-1:0] a);
		reg_index = a[7:2];
	endfunction

	assign wr_idx = reg_index(wr_addr);
	assign rd_idx = reg_index(rd_addr);
	assign fine_load_event_sel = fine_edge_config[CFG_LOAD_BIT];
	assign positioner_source_sel = fine_edge_config[CFG_SRC_BIT];
	assign fine_edge_select = fine_edge_config[CFG_EDGE_LO +: 2];
	assign cfg_write = wr_en && (wr_idx == IDX_CONFIG);

	// write error: unmapped, read-only, or locked config
	always_comb begin
		case (wr_idx)
		IDX_PHASE_FINE, IDX_COARSE_CTRL, IDX_FINE_CMP, IDX_COARSE_CMP,
		IDX_UNLOCK, IDX_COMBINED: wr_err = 1'b0;
		IDX_CONFIG: wr_err = !protected_write_unlock;
		default: wr_err = 1'b1;
		endcase
	end

	// unlock state, written by software
	always_ff @(posedge aclk) begin
		if (!aresetn)
			protected_write_unlock <= 1'b0;
		else if (wr_en && wr_idx == IDX_UNLOCK && wr_strb[0])
			protected_write_unlock <= wr_data[0];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			fine_edge_config <= CFG_RESET;
		else if (cfg_write && protected_write_unlock && wr_strb[0])
			fine_edge_config <= wr_data[3:0];
	end

	// coarse compare load mode
	always_ff @(posedge aclk) begin
		if (!aresetn)
			coarse_compare_control <= CCTRL_RESET;
		else if (wr_en && wr_idx == IDX_COARSE_CTRL && wr_strb[0])
			coarse_compare_control <= wr_data[1:0];
	end

	// phase step in upper byte only
	always_ff @(posedge aclk) begin
		if (!aresetn)
			phase_fine_field <= STEP_RESET;
		else if (wr_en && wr_idx == IDX_PHASE_FINE && wr_strb[1])
			phase_fine_field <= wr_data[STEP_LO +: 8];
	end

	always_comb begin
		fine_wr = 1'b0;
		coarse_wr = 1'b0;
		fine_wr_value = fine_shadow;
		coarse_wr_value = coarse_shadow;
		if (wr_en && wr_idx == IDX_COMBINED) begin
			fine_wr = wr_strb[1];
			fine_wr_value = wr_data[15:8];
			coarse_wr = |wr_strb[3:2];
			coarse_wr_value = hrec_merge16(coarse_shadow, wr_data[31:16], wr_strb[3:2]);
		end else if (wr_en && wr_idx == IDX_FINE_CMP) begin
			fine_wr = wr_strb[1];
			fine_wr_value = wr_data[15:8];
		end else if (wr_en && wr_idx == IDX_COARSE_CMP) begin
			coarse_wr = |wr_strb[1:0];
			coarse_wr_value = hrec_merge16(coarse_shadow, wr_data[15:0], wr_strb[1:0]);
		end
	end

	// load events for both shadow sets
	always_comb begin
		// phase mode uses fixed zero load
		if (positioner_source_sel)
			fine_load = counter_at_zero;
		else if (fine_load_event_sel)
			fine_load = counter_at_period;
		else
			fine_load = counter_at_zero;
		case (coarse_compare_control)
		CLOAD_ZERO: coarse_load = counter_at_zero;
		CLOAD_PRD: coarse_load = counter_at_period;
		CLOAD_EITHER: coarse_load = counter_at_zero || counter_at_period;
		CLOAD_FREEZE: coarse_load = 1'b0;
		default: coarse_load = 1'b0;
		endcase
	end

	hrec_shadow #(
		.WIDTH(8),
		.RESET_VALUE(STEP_RESET)
	) u_fine (
		.aclk(aclk),
		.aresetn(aresetn),
		.wr_en(fine_wr),
		.wr_value(fine_wr_value),
		.load(fine_load),
		.shadow(fine_shadow),
		.active(fine_active)
	);

	hrec_shadow #(
		.WIDTH(16),
		.RESET_VALUE(COARSE_RESET)
	) u_coarse (
		.aclk(aclk),
		.aresetn(aresetn),
		.wr_en(coarse_wr),
		.wr_value(coarse_wr_value),
		.load(coarse_load),
		.shadow(coarse_shadow),
		.active(compare_a_active)
	);

	assign next_step = positioner_source_sel ? phase_fine_field : fine_active;

	// positioner outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mep_step <= STEP_RESET;
			mep_rise_en <= 1'b0;
			mep_fall_en <= 1'b0;
		// zero step or disabled: no fine action
		end else if (fine_edge_select == EDGE_OFF || next_step == STEP_RESET) begin
			mep_step <= STEP_RESET;
			mep_rise_en <= 1'b0;
			mep_fall_en <= 1'b0;
		end else begin
			mep_step <= next_step;
			mep_rise_en <= fine_edge_select == EDGE_RISE || fine_edge_select == EDGE_BOTH;
			mep_fall_en <= fine_edge_select == EDGE_FALL || fine_edge_select == EDGE_BOTH;
		end
	end

	// coarse edges pass at coarse positions
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			edge_rise <= 1'b0;
			edge_fall <= 1'b0;
		end else begin
			edge_rise <= coarse_rise_req;
			edge_fall <= coarse_fall_req;
		end
	end

	// read decode, reserved bits zero
	always_comb begin
		rd_data = 32'h00000000;
		rd_err = 1'b0;
		case (rd_idx)
		IDX_PHASE_FINE: rd_data[15:8] = phase_fine_field;
		IDX_COARSE_CTRL: rd_data[1:0] = coarse_compare_control;
		IDX_FINE_CMP: rd_data[15:8] = fine_shadow;
		IDX_COARSE_CMP: rd_data[15:0] = coarse_shadow;
		IDX_CONFIG: rd_data[3:0] = fine_edge_config;
		IDX_UNLOCK: rd_data[0] = protected_write_unlock;
		IDX_COMBINED: rd_data = {coarse_shadow, fine_shadow, 8'h00};
		IDX_STATUS: rd_data = {compare_a_active, mep_step, 5'h00, mep_rise_en,
			mep_fall_en, protected_write_unlock};
		default: rd_err = 1'b1;
		endcase
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence locked_cfg_s;
		cfg_write && !protected_write_unlock;
	endsequence

	sequence duty_zero_load_s;
		!positioner_source_sel && !fine_load_event_sel && counter_at_zero && !fine_wr;
	endsequence

	locked_cfg_a: assert property (locked_cfg_s |=> $stable(fine_edge_config))
		else $error("config changed while locked");
	unlocked_cfg_a: assert property (cfg_write && protected_write_unlock && wr_strb[0]
		|=> fine_edge_config == $past(wr_data[3:0]))
		else $error("unlocked config write lost");
	zero_load_a: assert property (duty_zero_load_s ##1 1'b1
		|-> fine_active == $past(fine_shadow))
		else $error("fine load on zero missed");
	period_load_a: assert property (!positioner_source_sel && fine_load_event_sel
		&& counter_at_period && !counter_at_zero |=> fine_active == $past(fine_shadow))
		else $error("fine load on period missed");
	phase_noload_a: assert property (positioner_source_sel && counter_at_period
		&& !counter_at_zero |=> $stable(fine_active))
		else $error("fine load in phase mode");
	edge_off_a: assert property (fine_edge_select == EDGE_OFF
		|=> !mep_rise_en && !mep_fall_en)
		else $error("fine edge active while off");
	phase_src_a: assert property (positioner_source_sel && fine_edge_select != EDGE_OFF
		|=> mep_step == $past(phase_fine_field))
		else $error("phase step not used");
	zero_step_a: assert property (next_step == STEP_RESET |=> !mep_rise_en && !mep_fall_en)
		else $error("fine action with zero step");
	combined_wr_a: assert property (wr_en && wr_idx == IDX_COMBINED && wr_strb == 4'hF
		|=> fine_shadow == $past(wr_data[15:8])
		&& coarse_shadow == $past(wr_data[31:16]))
		else $error("combined write incomplete");
	coarse_edge_a: assert property (coarse_rise_req ##1 1'b1 |-> edge_rise)
		else $error("coarse rise edge lost");
	// phase register low byte reads zero
	phase_res_a: assert property (rvalid && $rose(rvalid) && $past(rd_idx) == IDX_PHASE_FINE
		|-> rdata[7:0] == 8'h00)
		else $error("phase reserved byte not zero");
endmodule

/* verilog/hrec_shadow.sv */
// Purpose: shadow and active pair of one compare value
// Assumes: load is a one-cycle pulse on the same clock
// Notes: a write in the load cycle lands in the shadow only
`timescale 1ns/10ps
module hrec_shadow #(
	parameter int WIDTH = 16,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic wr_en,
	input wire logic [WIDTH-1:0] wr_value,
	input wire logic load,
	output logic [WIDTH-1:0] shadow,
	output logic [WIDTH-1:0] active
);
	// software side copy
	always_ff @(posedge aclk) begin
		if (!aresetn)
			shadow <= RESET_VALUE;
		else if (wr_en)
			shadow <= wr_value;
	end

	// copy on the selected counter event
	always_ff @(posedge aclk) begin
		if (!aresetn)
			active <= RESET_VALUE;
		else if (load)
			active <= shadow;
	end
endmodule
